// *** flash_page_erase_program_control_test.sv ***
// Purpose: Self-checking bench for the erase-program sequencer.
// Assumes: PHASE_LEN shortened to 100 cycles.
// Notes:   Programming strobes are logged and compared byte by byte.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module flash_page_erase_program_control_test
   import fpe_pkg::*;
;
   localparam int PL = 100;
   logic          mclk = 0, rst = 1, irq_pending = 0, bod_enabled = 1, hv_fault = 0;
   logic          bod_trip = 0;
   logic          page_secured = 0, sfr_wr, sfr_rd, cpu_hold, flash_erase, flash_prog;
   logic [7:0]    sfr_addr, sfr_wdata, sfr_rdata, st;
   fpe_flash_wr_t flash_wr;
   fpe_flash_wr_t prog_q[$];
   fpe_flash_wr_t exp_q[$];
   int            n_mismatch = 0, cmp_count = 0, n_erase = 0;
   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      if (flash_prog) prog_q.push_back(flash_wr);
      if (flash_erase) n_erase++;
   end
   fpe_core_model u_core (.mclk(mclk), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
   fpe_ctrl #(.PHASE_LEN(PL)) u_dut (.mclk(mclk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .irq_pending(irq_pending), .bod_enabled(bod_enabled), .bod_trip(bod_trip),
      .hv_fault(hv_fault), .page_secured(page_secured), .cpu_hold(cpu_hold),
      .icp_active(1'b0), .icp_erase(1'b0), .icp_wr(1'b0), .icp_addr(14'h0000),
      .icp_data(8'h00), .flash_erase(flash_erase), .flash_prog(flash_prog), .flash_wr(flash_wr));
   function automatic fpe_flash_wr_t exp_wr(logic [7:0] ah, logic [7:0] al, int i, logic [7:0] d);
      return {ah[5:0], al[7:6], 6'(al[5:0] + i), d};
   endfunction
   // Aborts after ab + 2 cycles when ab is nonzero: by interrupt, or by brown-out when bo is set.
   task automatic run_ep(input int ab, input logic bo);
      u_core.wr(ADDR_CMD_STATUS, CMD_ERASE_PROGRAM);
      `CHK("cycle start", 1'b1, cpu_hold)
      repeat (ab + 2) @(negedge mclk);
      irq_pending = ab > 0 && !bo;
      bod_trip = ab > 0 && bo;
      for (int i = 0; i < 4 * PL && cpu_hold !== 1'b0; i++) @(negedge mclk);
      irq_pending = 1'b0;
      bod_trip = 1'b0;
      `CHK("cpu_hold", 1'b0, cpu_hold)
   endtask
   task automatic status(input logic [7:0] e);
      u_core.rd(ADDR_CMD_STATUS, st);
      `CHK("status", e, st)
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      complete_run();
   end
   initial begin
      logic [7:0] ah, al, d[6];
      int cnt;
      int j;
      void'($urandom(32'h62d2));
      repeat (5) @(negedge mclk);
      rst = 0;
      for (int t = 0; t < 2; t++) begin
         ah = 8'($urandom);
         al = {2'($urandom), 6'h3E};
         cnt = 1 + $urandom % 6;
         u_core.wr(ADDR_CMD_STATUS, CMD_LOAD);
         u_core.wr(ADDR_ADDR_HIGH, ah);
         u_core.wr(ADDR_ADDR_LOW, al);
         for (int i = 0; i < cnt; i++) begin
            d[i] = 8'($urandom);
            u_core.wr(ADDR_DATA_IN, d[i]);
         end
         u_core.rd(ADDR_ADDR_LOW, st);
         `CHK("pointer", {al[7:6], 6'(al[5:0] + cnt)}, st)
         u_core.wr(ADDR_CMD_STATUS, 8'h55);
         prog_q.delete();
         n_erase = 0;
         run_ep(0, 1'b0);
         status(8'h00);
         `CHK("erase count", cnt, n_erase)
         `CHK("prog count", cnt, prog_q.size())
         // The array is walked in ascending location order, not in load order.
         exp_q.delete();
         for (int k = 0; k < PAGE_BYTES; k++) begin
            j = 6'(k - al[5:0]);
            if (j < cnt) exp_q.push_back(exp_wr(ah, al, j, d[j]));
         end
         foreach (prog_q[i]) `CHK("prog byte", exp_q[i], prog_q[i])
         $display("page update %0d done", t);
      end
      page_secured = 1;
      u_core.wr(ADDR_CMD_STATUS, CMD_ERASE_PROGRAM);
      page_secured = 0;
      status(8'h02);
      u_core.wr(ADDR_CMD_STATUS, CMD_LOAD);
      status(8'h00);
      bod_enabled = 0;
      u_core.wr(ADDR_CMD_STATUS, CMD_ERASE_PROGRAM);
      bod_enabled = 1;
      status(8'h08);
      $display("refusals done");
      run_ep(20, 1'b0);
      status(8'h09);
      run_ep(30, 1'b1);
      status(8'h08);
      u_core.wr(ADDR_CMD_STATUS, CMD_LOAD);
      hv_fault = 1;
      repeat (4) @(negedge mclk);
      hv_fault = 0;
      status(8'h04);
      $display("faults done");
      complete_run();
   end
endmodule

// *** fpe_core_model.sv ***
// Purpose: Firmware-side model that reaches the registers.
// Assumes: Accesses launch on the falling edge of mclk.
// Notes:   Idle address and data show the inverse of the last value.
`timescale 1ns/100ps
module fpe_core_model (
   input  wire logic       mclk,
   output logic            sfr_wr,
   output logic            sfr_rd,
   output logic [7:0]      sfr_addr,
   output logic [7:0]      sfr_wdata,
   input  wire logic [7:0] sfr_rdata
);
   initial {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
      @(negedge mclk);
      {sfr_wr, sfr_addr, sfr_wdata} = {1'b0, ~a, ~d};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      {sfr_rd, sfr_addr} = {1'b1, a};
      @(negedge mclk);
      {sfr_rd, sfr_addr} = {1'b0, ~a};
      @(negedge mclk);
      d = sfr_rdata;
   endtask
endmodule

// *** fpe_ctrl.sv ***
// Purpose: Byte-granular erase-program sequencer for a 64-byte code flash page.
// Assumes: Core reaches the four registers by sfr_* strobes on mclk.
// Notes:   The flash macro performs the actual charge work per strobe.
`timescale 1ns/100ps
module fpe_ctrl
   import fpe_pkg::*;
#(
   parameter int PHASE_LEN = PHASE_CYCLES
) (
   // Clock and reset.
   input  wire logic          mclk,
   input  wire logic          rst,
   // Special-function register port.
   input  wire logic          sfr_wr,
   input  wire logic          sfr_rd,
   input  wire logic [7:0]    sfr_addr,
   input  wire logic [7:0]    sfr_wdata,
   output logic [7:0]         sfr_rdata,
   // System conditions.
   input  wire logic          irq_pending,
   input  wire logic          bod_enabled,
   input  wire logic          bod_trip,
   input  wire logic          hv_fault,
   input  wire logic          page_secured,
   output logic               cpu_hold,
   // External two-wire programmer path, already decoded.
   input  wire logic          icp_active,
   input  wire logic          icp_erase,
   input  wire logic          icp_wr,
   input  wire logic [13:0]   icp_addr,
   input  wire logic [7:0]    icp_data,
   // Flash array side.
   output logic               flash_erase,
   output logic               flash_prog,
   output fpe_flash_wr_t      flash_wr
);

   // The strobe is kept outside so that every caller names it and sees it change.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction

   logic [7:0]          flash_addr_low;
   logic [7:0]          flash_addr_high;
   logic [7:0]          page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] upd_flag;
   logic [3:0]          status;
   fpe_state_t          state;
   logic [31:0]         tmr;
   logic [PTR_W-1:0]    idx;
   logic                cmd_wr;
   logic                data_wr;
   logic                irq_s1, irq_s2, bod_s1, bod_s2, hvf_s1, hvf_s2;
   logic                start_ok;
   logic                busy;
   logic                phase_done;
   logic                abort_req;

   assign cmd_wr     = sfr_wr && hit(sfr_addr, ADDR_CMD_STATUS);
   assign data_wr    = sfr_wr && hit(sfr_addr, ADDR_DATA_IN);
   assign abort_req  = irq_s2 || bod_s2 || hvf_s2;
   assign busy       = (state != FPE_IDLE);
   assign phase_done = (tmr == 32'(PHASE_LEN - 1));
   assign start_ok   = cmd_wr && (sfr_wdata == CMD_ERASE_PROGRAM) && !page_secured;
   assign cpu_hold   = busy;

   // Pins from outside the clock domain pass two flip-flops.
   always_ff @(posedge mclk) begin
      irq_s1 <= irq_pending;
      irq_s2 <= irq_s1;
      bod_s1 <= bod_trip;
      bod_s2 <= bod_s1;
      hvf_s1 <= hv_fault;
      hvf_s2 <= hvf_s1;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         flash_addr_low  <= ADDR_RESET;
         flash_addr_high <= ADDR_RESET;
      end else if (!busy) begin
         if (sfr_wr && hit(sfr_addr, ADDR_ADDR_HIGH)) begin
            flash_addr_high <= sfr_wdata;
         end
         if (sfr_wr && hit(sfr_addr, ADDR_ADDR_LOW)) begin
            flash_addr_low <= sfr_wdata;
         end else if (data_wr) begin
            flash_addr_low[PTR_W-1:0] <= flash_addr_low[PTR_W-1:0] + 6'h01;
         end
      end
   end

   // load clears buffer; other codes ignored
   always_ff @(posedge mclk) begin
      if (rst) begin
         upd_flag <= '0;
      end else if (cmd_wr && !busy && sfr_wdata == CMD_LOAD) begin
         upd_flag <= '0;
      end else if (data_wr && !busy) begin
         upd_flag[flash_addr_low[PTR_W-1:0]] <= 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < PAGE_BYTES; g++) begin : g_buf
         always_ff @(posedge mclk) begin
            if (rst) begin
               page_buf[g] <= 8'h00;
            end else if (cmd_wr && !busy && sfr_wdata == CMD_LOAD) begin
               page_buf[g] <= 8'h00;
            end else if (data_wr && !busy && flash_addr_low[PTR_W-1:0] == PTR_W'(g)) begin
               page_buf[g] <= sfr_wdata;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= FPE_IDLE;
         tmr   <= 32'h0;
      end else begin
         case (state)
            FPE_IDLE: begin
               tmr <= 32'h0;
               if (start_ok && !icp_active && bod_enabled) begin
                  state <= FPE_ERASE;
               end
            end
            FPE_ERASE, FPE_PROGRAM: begin
               if (abort_req) begin
                  state <= FPE_IDLE;
               end else if (phase_done) begin
                  tmr   <= 32'h0;
                  state <= (state == FPE_ERASE) ? FPE_PROGRAM : FPE_IDLE;
               end else begin
                  tmr <= tmr + 32'h1;
               end
            end
            default: state <= FPE_IDLE;
         endcase
      end
   end

   // Status flags: set wins over the clearing command write.
   always_ff @(posedge mclk) begin
      if (rst) begin
         status <= STATUS_RESET;
      end else begin
         if (cmd_wr && !busy) begin
            status <= STATUS_RESET;
         end
         if (cmd_wr && !busy && sfr_wdata == CMD_ERASE_PROGRAM && page_secured) begin
            status[FLAG_SV] <= 1'b1;
         end
         if (start_ok && !busy && !bod_enabled) begin
            status[FLAG_HVA] <= 1'b1;
         end
         if (hvf_s2) begin
            status[FLAG_HVE] <= 1'b1;
         end
         if (busy && irq_s2) begin
            status[FLAG_OI] <= 1'b1;
         end
         if (busy && (irq_s2 || bod_s2)) begin
            status[FLAG_HVA] <= 1'b1;
         end
      end
   end

   // walk every byte; strobe only flagged bytes
   // The walk restarts with each phase so the program pass sees every location.
   always_ff @(posedge mclk) begin
      if (rst || !busy || phase_done) begin
         idx <= '0;
      end else if (idx != PTR_W'(PAGE_BYTES - 1)) begin
         idx <= idx + 6'h01;
      end
   end

   // Array strobes: one byte per cycle at the start of each phase.
   always_ff @(posedge mclk) begin
      if (rst) begin
         flash_erase <= 1'b0;
         flash_prog  <= 1'b0;
         flash_wr    <= '0;
      end else if (busy && !abort_req && upd_flag[idx] && tmr < 32'(PAGE_BYTES)) begin
         flash_erase <= (state == FPE_ERASE);
         flash_prog  <= (state == FPE_PROGRAM);
         flash_wr    <= {flash_addr_high[5:0], flash_addr_low[7:6], idx, page_buf[idx]};
      end else if (!busy && icp_active && (icp_wr || icp_erase)) begin
         flash_erase <= icp_erase;
         flash_prog  <= icp_wr;
         flash_wr    <= {icp_addr, icp_data};
      end else begin
         flash_erase <= 1'b0;
         flash_prog  <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         case (sfr_addr)
            ADDR_CMD_STATUS: sfr_rdata <= {4'h0, status};
            ADDR_ADDR_LOW:   sfr_rdata <= flash_addr_low;
            ADDR_ADDR_HIGH:  sfr_rdata <= flash_addr_high;
            default:         sfr_rdata <= 8'h00;
         endcase
      end
   end

endmodule

// *** fpe_monitor.sv ***
// Purpose: Port checker for the erase-program sequencer.
// Assumes: One clock domain; PHASE_LEN equals the design's.
// Notes:   Cycle length is only judged when no abort source was seen.
`timescale 1ns/100ps
module fpe_monitor
   import fpe_pkg::*;
#(
   parameter int PHASE_LEN = PHASE_CYCLES
) (
   // Clock and reset.
   input wire logic       mclk,
   input wire logic       rst,
   // Register port.
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // Conditions and flash side.
   input wire logic       irq_pending,
   input wire logic       bod_enabled,
   input wire logic       bod_trip,
   input wire logic       hv_fault,
   input wire logic       page_secured,
   input wire logic       cpu_hold,
   input wire logic       flash_erase,
   input wire logic       flash_prog
);
   int   hold_cnt;
   logic abort_seen;
   logic ep_wr;
   assign ep_wr = sfr_wr && sfr_addr == ADDR_CMD_STATUS && !cpu_hold;
   always_ff @(posedge mclk) begin
      hold_cnt <= (rst || !cpu_hold) ? 0 : hold_cnt + 1;
      abort_seen <= (rst || !cpu_hold) ? 1'b0
                    : (abort_seen || irq_pending || bod_trip || hv_fault);
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   chk_start_cycle: assert property (ep_wr && sfr_wdata == CMD_ERASE_PROGRAM
      && !page_secured && bod_enabled |=> cpu_hold) else $error("cycle did not start");
   chk_secure_refuse: assert property (ep_wr && sfr_wdata == CMD_ERASE_PROGRAM
      && page_secured |=> !cpu_hold [*2]) else $error("secured page started");
   chk_bod_refuse: assert property (ep_wr && sfr_wdata == CMD_ERASE_PROGRAM
      && !bod_enabled |=> !cpu_hold [*2]) else $error("cycle ran without brown-out guard");
   chk_other_cmd: assert property (ep_wr && sfr_wdata != CMD_ERASE_PROGRAM
      |=> !cpu_hold [*2]) else $error("other command started a cycle");
   chk_status_upper: assert property (sfr_rd && sfr_addr == ADDR_CMD_STATUS
      |=> sfr_rdata[7:4] == 4'h0) else $error("reserved status bits set");
   chk_cycle_len: assert property ($fell(cpu_hold) && !abort_seen
      |-> hold_cnt == 2 * PHASE_LEN) else $error("cycle length wrong");
   chk_erase_phase: assert property (flash_erase
      |-> cpu_hold && hold_cnt <= PHASE_LEN) else $error("erase outside erase phase");
   chk_prog_phase: assert property (flash_prog
      |-> cpu_hold && hold_cnt >= PHASE_LEN - 1) else $error("program before erase ended");
   cover property ($fell(cpu_hold) && !abort_seen);
   cover property ($fell(cpu_hold) && abort_seen);
   cover property (ep_wr && page_secured);
endmodule
bind fpe_ctrl fpe_monitor #(.PHASE_LEN(PHASE_LEN)) u_mon (.*);

// *** fpe_pkg.sv ***
// Purpose: Shared constants and types for the flash page erase-program control.
// Assumes: 250 MHz mclk; byte-wide special-function register port.
// Notes:   All offsets, codes, flag positions and timing counts live here.
package fpe_pkg;

   // Special-function register addresses.
   localparam logic [7:0] ADDR_CMD_STATUS = 8'hE4;
   localparam logic [7:0] ADDR_ADDR_LOW   = 8'hE5;
   localparam logic [7:0] ADDR_ADDR_HIGH  = 8'hE6;
   localparam logic [7:0] ADDR_DATA_IN    = 8'hE7;

   // Command codes.
   localparam logic [7:0] CMD_LOAD          = 8'h00;
   localparam logic [7:0] CMD_ERASE_PROGRAM = 8'h68;

   // Status flag positions and reset values.
   localparam int         FLAG_OI  = 0;
   localparam int         FLAG_SV  = 1;
   localparam int         FLAG_HVE = 2;
   localparam int         FLAG_HVA = 3;
   localparam logic [3:0] STATUS_RESET = 4'h0;
   localparam logic [7:0] ADDR_RESET   = 8'h00;

   // Page geometry.
   localparam int PAGE_BYTES = 64;
   localparam int PTR_W      = 6;

   // Timing: each phase lasts 2 ms.
   localparam real CLK_MHZ     = 250.0;
   localparam real PHASE_MS    = 2.0;
   localparam int  PHASE_CYCLES = int'(PHASE_MS * 1000.0 * CLK_MHZ);

   typedef enum logic [1:0] {
      FPE_IDLE    = 2'b00,
      FPE_ERASE   = 2'b01,
      FPE_PROGRAM = 2'b10
   } fpe_state_t;

   // One write strobe towards the flash array.
   typedef struct packed {
      logic [13:0] addr;
      logic [7:0]  data;
   } fpe_flash_wr_t;

endpackage
